// [inc/ctmc_pkg.sv]
// Package with constants and types for the CAN transceiver mode control block.
// Summary of operation
// - The transmit data input bit stream is turned into the matching differential bus state.
// - In Normal-operating mode the bus state is sensed and forwarded to the controller on the receive data output.
// - Four modes exist, power-on reset included, chosen from the reference supply, mode select and undervoltage.
// - Normal-operating mode both transmits onto and receives from the bus.
// - Forced-power-save behaves like Power-save and is entered on transmitter undervoltage.
// - With the reference supply good the mode state machine runs and accepts mode changes.
// - With the reference supply low the device is held in a power-on-reset state.
// - Normal-operating mode may be entered only while the reference supply is good.
// - A time-out detects a transmit data input held dominant for too long.
// - The data paths serve bit rates up to 2 Mbit/s including the fast data phase.
// - When unpowered the bus pins stay passive so other traffic is not disturbed.
// - Mode select high gives Power-save; low gives Normal without undervoltage, else Forced.
// - A low transmit input gives a dominant bus, a high one a recessive bus.
// - The transmit input reaches the bus only in Normal-operating mode.
// - A floating mode select is pulled up so the device defaults to Power-save.
package ctmc_pkg;

  // ****************************************
  // Modes and bus levels
  // ****************************************
  typedef enum logic [1:0] {
    CTMC_POR = 2'h0,
    CTMC_PSAVE = 2'h1,
    CTMC_FPSAVE = 2'h2,
    CTMC_NORMAL = 2'h3
  } ctmc_mode_t;

  localparam logic LVL_DOMINANT = 1'h0;
  localparam logic LVL_RECESSIVE = 1'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int MAX_BIT_RATE = 2000000;
  // Dominant time-out in microseconds; no figure is given, so a plain default is used.
  localparam int TXD_TIMEOUT_US = 1000;
  localparam int TXD_TIMEOUT_CYC = (TXD_TIMEOUT_US * (CLK_HZ / 1000000) > 0) ?
                                   TXD_TIMEOUT_US * (CLK_HZ / 1000000) : 1;
  localparam int CYC_PER_BIT = CLK_HZ / MAX_BIT_RATE;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic io_ok;
    logic tx_uv;
    logic sel_n;
  } ctmc_ctl_t;

  typedef struct packed {
    logic drive_dom;
    logic rx_data;
  } ctmc_path_t;

endpackage : ctmc_pkg

// [hdl/ctmc_mode_fsm.sv]
// Operating mode state machine of the CAN transceiver.
`timescale 1ns/1ns
`default_nettype none
module ctmc_mode_fsm (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control inputs
  input wire ctmc_pkg::ctmc_ctl_t ctl,
  // Mode
  output var ctmc_pkg::ctmc_mode_t mode_q
);

  ctmc_pkg::ctmc_mode_t mode_d;

  // The mode follows the inputs every cycle, so any change is seen at the next edge.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ctmc_pkg::CTMC_POR,
      ctmc_pkg::CTMC_PSAVE,
      ctmc_pkg::CTMC_FPSAVE,
      ctmc_pkg::CTMC_NORMAL: begin
        if (!ctl.io_ok) begin
          mode_d = ctmc_pkg::CTMC_POR;
        end else if (ctl.sel_n) begin
          mode_d = ctmc_pkg::CTMC_PSAVE;
        end else if (ctl.tx_uv) begin
          mode_d = ctmc_pkg::CTMC_FPSAVE;
        end else begin
          mode_d = ctmc_pkg::CTMC_NORMAL;
        end
      end
      default: begin
        mode_d = ctmc_pkg::CTMC_POR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= ctmc_pkg::CTMC_POR;
    end else begin
      mode_q <= mode_d;
    end
  end

  property p_por_hold;
    @(posedge clk) disable iff (!rst_b)
      !ctl.io_ok |=> mode_q == ctmc_pkg::CTMC_POR;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("not in reset with low supply");

  property p_normal_ok;
    @(posedge clk) disable iff (!rst_b)
      mode_q == ctmc_pkg::CTMC_NORMAL |-> $past(ctl.io_ok) && !$past(ctl.tx_uv);
  endproperty
  a_normal_ok: assert property (p_normal_ok) else $error("normal entered without supply");

  property p_psave;
    @(posedge clk) disable iff (!rst_b)
      ctl.io_ok && ctl.sel_n |=> mode_q == ctmc_pkg::CTMC_PSAVE;
  endproperty
  a_psave: assert property (p_psave) else $error("select high did not give power save");

  property p_fpsave;
    @(posedge clk) disable iff (!rst_b)
      ctl.io_ok && !ctl.sel_n && ctl.tx_uv |=> mode_q == ctmc_pkg::CTMC_FPSAVE;
  endproperty
  a_fpsave: assert property (p_fpsave) else $error("undervoltage did not force power save");

endmodule : ctmc_mode_fsm
`default_nettype wire

// [hdl/ctmc_dom_timer.sv]
// Dominant time-out timer on the transmit data input.
`timescale 1ns/1ns
`default_nettype none
module ctmc_dom_timer #(
  parameter int TIMEOUT_CYC = ctmc_pkg::TXD_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Transmit input and enable
  input wire logic txd,
  input wire logic enable,
  // Time-out flag
  output var logic timeout_q
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  // A zero count would leave the counter without a terminal value.
  if (TIMEOUT_CYC < 1) begin : g_cyc_chk
    $error("TIMEOUT_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic timeout_d;

  // The block is released by a recessive level or by leaving Normal mode, so a shorted input stays blocked in Normal.
  always_comb begin
    cnt_d = cnt_q;
    timeout_d = timeout_q;
    if (!enable || txd == ctmc_pkg::LVL_RECESSIVE) begin
      cnt_d = '0;
      timeout_d = 1'b0;
    end else if (cnt_q == CW'(TIMEOUT_CYC - 1)) begin
      timeout_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      timeout_q <= timeout_d;
    end
  end

  property p_timeout_clear;
    @(posedge clk) disable iff (!rst_b)
      txd == ctmc_pkg::LVL_RECESSIVE |=> !timeout_q;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) else $error("time-out kept on recessive");

  property p_timeout_cause;
    @(posedge clk) disable iff (!rst_b)
      $rose(timeout_q) |-> $past(cnt_q) == CW'(TIMEOUT_CYC - 1);
  endproperty
  a_timeout_cause: assert property (p_timeout_cause) else $error("time-out at wrong count");

endmodule : ctmc_dom_timer
`default_nettype wire

// [hdl/ctmc_top.sv]
// Top of the CAN transceiver mode control and data path.
`timescale 1ns/1ns
`default_nettype none
module ctmc_top #(
  parameter int TXD_TIMEOUT_CYC = ctmc_pkg::TXD_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Supply status
  input wire logic IO_REFERENCE_SUPPLY_OK,
  input wire logic TRANSMITTER_SUPPLY_UNDERVOLTAGE,
  // Controller side
  input wire logic MODE_SELECT_N,
  input wire logic MODE_SELECT_N_OE,
  input wire logic TXD,
  output var logic RXD,
  // Bus side
  input wire logic BUS_DOMINANT,
  output var logic BUS_DRIVE_DOM,
  output var logic BUS_OE,
  // Status
  output var logic [1:0] MODE,
  output var logic TXD_TIMEOUT
);

  // The registered data path needs a few clocks per bit at the top rate.
  if (ctmc_pkg::CYC_PER_BIT < 4) begin : g_rate_chk
    $error("clock too slow for the highest bit rate");
  end

  // ****************************************
  // Mode selection
  // ****************************************
  ctmc_pkg::ctmc_ctl_t ctl;
  ctmc_pkg::ctmc_mode_t mode;
  logic timeout;

  always_comb begin
    ctl.io_ok = IO_REFERENCE_SUPPLY_OK;
    ctl.tx_uv = TRANSMITTER_SUPPLY_UNDERVOLTAGE;
    // An undriven select reads high through the pull-up.
    ctl.sel_n = MODE_SELECT_N_OE ? MODE_SELECT_N : 1'b1;
  end

  ctmc_mode_fsm u_fsm (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .ctl(ctl),
    .mode_q(mode)
  );

  ctmc_dom_timer #(
    .TIMEOUT_CYC(TXD_TIMEOUT_CYC)
  ) u_tmr (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .txd(TXD),
    .enable(mode == ctmc_pkg::CTMC_NORMAL),
    .timeout_q(timeout)
  );

  // ****************************************
  // Data path
  // ****************************************
  // One register stage keeps latency at one 50 ns cycle, well inside a 500 ns bit.
  ctmc_pkg::ctmc_path_t path_q;
  ctmc_pkg::ctmc_path_t path_d;
  logic oe_q;
  logic oe_d;

  always_comb begin
    path_d.drive_dom = 1'b0;
    path_d.rx_data = ctmc_pkg::LVL_RECESSIVE;
    oe_d = 1'b0;
    if (mode == ctmc_pkg::CTMC_NORMAL) begin
      // Blocked input still leaves the receiver running.
      path_d.drive_dom = (TXD == ctmc_pkg::LVL_DOMINANT) && !timeout;
      oe_d = path_d.drive_dom;
      path_d.rx_data = BUS_DOMINANT ? ctmc_pkg::LVL_DOMINANT : ctmc_pkg::LVL_RECESSIVE;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      path_q <= '{drive_dom: 1'b0, rx_data: ctmc_pkg::LVL_RECESSIVE};
      oe_q <= 1'b0;
    end else begin
      path_q <= path_d;
      oe_q <= oe_d;
    end
  end

  always_comb begin
    RXD = path_q.rx_data;
    BUS_DRIVE_DOM = path_q.drive_dom;
    BUS_OE = oe_q;
  end

  // Status outputs come from flops; MODE is the FSM register itself.
  always_comb begin
    MODE = mode;
    TXD_TIMEOUT = timeout;
  end

  property p_blocked;
    @(posedge CLK_SYS) disable iff (!RST_B)
      mode != ctmc_pkg::CTMC_NORMAL |=> !BUS_DRIVE_DOM && !BUS_OE;
  endproperty
  a_blocked: assert property (p_blocked) else $error("bus driven outside normal mode");

  property p_rx_rec;
    @(posedge CLK_SYS) disable iff (!RST_B)
      mode != ctmc_pkg::CTMC_NORMAL |=> RXD == ctmc_pkg::LVL_RECESSIVE;
  endproperty
  a_rx_rec: assert property (p_rx_rec) else $error("receive active in power save");

  property p_tx_dom;
    @(posedge CLK_SYS) disable iff (!RST_B)
      mode == ctmc_pkg::CTMC_NORMAL && !TXD && !timeout |=> BUS_DRIVE_DOM && BUS_OE;
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("dominant not sent");

  property p_tx_rec;
    @(posedge CLK_SYS) disable iff (!RST_B)
      TXD |=> !BUS_DRIVE_DOM;
  endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("recessive input drove bus");

  property p_rx_fwd;
    @(posedge CLK_SYS) disable iff (!RST_B)
      mode == ctmc_pkg::CTMC_NORMAL |=> RXD == !$past(BUS_DOMINANT);
  endproperty
  a_rx_fwd: assert property (p_rx_fwd) else $error("bus state not forwarded");

  property p_float;
    @(posedge CLK_SYS) disable iff (!RST_B)
      IO_REFERENCE_SUPPLY_OK && !MODE_SELECT_N_OE ##1 1'b1 |-> MODE == ctmc_pkg::CTMC_PSAVE;
  endproperty
  a_float: assert property (p_float) else $error("floating select not power save");

endmodule : ctmc_top
`default_nettype wire

// [tb/ctmc_ctrl_model.sv]
// Behavioural model of the protocol controller that drives the transceiver pins.
`timescale 1ns/1ns
`default_nettype none
module ctmc_ctrl_model (
  // Clock
  input wire logic clk,
  // Commands from the bench: 0 float, 1 select high, 2 select low
  input wire logic [1:0] sel_cmd,
  input wire logic tx_bit,
  // Pins toward the transceiver
  output var logic txd,
  output var logic sel_n,
  output var logic sel_oe
);
  initial begin
    txd = 1'h1;
    sel_n = 1'h1;
    sel_oe = 1'h0;
  end

  always @(negedge clk) begin
    txd <= tx_bit;
    sel_oe <= (sel_cmd != 2'h0);
    // A released pin toggles so that a stale level can never pass for a real one.
    if (sel_cmd == 2'h0) begin
      sel_n <= ~sel_n;
    end else begin
      sel_n <= sel_cmd[0];
    end
  end
endmodule : ctmc_ctrl_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the transceiver mode control block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int N = 8;
  logic clk, rst_b, io_ok, uv, bus_dom, tx_bit;
  logic txd, sel_n, sel_oe, rxd, drv, oe, tmo;
  logic [1:0] sel_cmd, mode;
  logic [15:0] lfsr;
  int err_total, comparisons, cyc, wd, em, erx, edom, eto, run;

  ctmc_top #(.TXD_TIMEOUT_CYC(N)) dut_u (.CLK_SYS(clk), .RST_B(rst_b),
    .IO_REFERENCE_SUPPLY_OK(io_ok), .TRANSMITTER_SUPPLY_UNDERVOLTAGE(uv),
    .MODE_SELECT_N(sel_n), .MODE_SELECT_N_OE(sel_oe), .TXD(txd), .RXD(rxd),
    .BUS_DOMINANT(bus_dom), .BUS_DRIVE_DOM(drv), .BUS_OE(oe), .MODE(mode),
    .TXD_TIMEOUT(tmo));

  ctmc_ctrl_model ctrl_u (.clk(clk), .sel_cmd(sel_cmd), .tx_bit(tx_bit), .txd(txd),
    .sel_n(sel_n), .sel_oe(sel_oe));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Reference model
  // ****************************************
  // The flag rises after N low cycles in normal mode, and driving stops one cycle later.
  always @(posedge clk) begin
    if (!rst_b) begin
      em = 0; erx = 1; edom = 0; eto = 0; run = 0;
    end else begin
      erx = (em == 3) ? !bus_dom : 1;
      run = (em == 3 && txd == 1'h0) ? run + 1 : 0;
      eto = (run >= N);
      edom = (em == 3 && txd == 1'h0 && run <= N);
      em = !io_ok ? 0 : ((!sel_oe || sel_n) ? 1 : (uv ? 2 : 3));
    end
  end

  // ****************************************
  // Clock, watchdog and stimulus
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial wd = 0;
  always @(posedge clk) begin
    wd++;
    if (wd >= 4000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    rst_b = 1'h0; io_ok = 1'h1; uv = 1'h0; bus_dom = 1'h0; tx_bit = 1'h1;
    sel_cmd = 2'h2; lfsr = 16'h000C; err_total = 0; comparisons = 0;
    repeat (10) @(negedge clk);
    rst_b = 1'h1;
    for (cyc = 0; cyc < 3000; cyc++) begin
      @(negedge clk);
      chk({2'h0, mode}, 4'(em));
      chk({3'h0, rxd}, 4'(erx));
      chk({3'h0, oe}, 4'(edom));
      chk({3'h0, drv}, 4'(edom));
      chk({3'h0, tmo}, 4'(eto));
      lfsr = lfsr_next(lfsr);
      if (cyc % 32 == 20) begin
        io_ok <= (lfsr[3:0] != 4'h0);
        uv <= (lfsr[5:4] == 2'h3);
        sel_cmd <= (lfsr[7:6] == 2'h0) ? 2'h0 : ((lfsr[7:6] == 2'h1) ? 2'h1 : 2'h2);
      end
      // Each forced 12-cycle burst of low bits is long enough to run into the time-out.
      tx_bit <= (cyc % 64 < 12) ? 1'h0 : lfsr[8];
      bus_dom <= drv | (lfsr[9] & lfsr[10]);
      rst_b <= !(cyc >= 1500 && cyc < 1503);
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
